// ### logic/ccmivb_regs.svh
/*
  Constants for the packet-number IV builder: IV octet layout, fixed codes and field widths.
  Assumes inclusion by bare name from every design file of the block.
*/
`ifndef CCMIVB_REGS_SVH
`define CCMIVB_REGS_SVH
`define CCMIVB_IV_FLAGS 8'h09
`define CCMIVB_IV_NRESV 8'h00
`define CCMIVB_IV_FIXED 8'h00
`define CCMIVB_B12_RSV 4'h0
`define CCMIVB_DIR_F2P 1'b0
`define CCMIVB_DIR_P2F 1'b1
`define CCMIVB_PN_W 48
`define CCMIVB_SN_W 9
`define CCMIVB_SN_NARROW 8
`define CCMIVB_PN_ZERO 48'h000000000000
`define CCMIVB_PN_STEP_EXT 48'h000000000200
`define CCMIVB_PN_STEP_NARROW 48'h000000000100
`define CCMIVB_LCN_W 3
`define CCMIVB_FPI_W 12
`define CCMIVB_PPI_W 20
`define CCMIVB_LEN_W 16
`endif

// ### logic/ccmivb_pkg.sv
/*
  Types for the IV builder link; only the builder end uses them.
  Assumes ccmivb_regs.svh is compiled with it.
*/
`default_nettype none
`include "ccmivb_regs.svh"
package ccmivb_pkg;
  typedef logic [127:0] ccmivb_iv_t;
  typedef logic [`CCMIVB_PN_W-1:0] ccmivb_pn_t;
  typedef enum logic {CCMIVB_TX, CCMIVB_RX} ccmivb_role_t;
endpackage : ccmivb_pkg
`default_nettype wire

// ### logic/ccmivb_if.sv
/*
  Carrier between the link framer end and the IV builder end.
  Assumes one clock shared by both ends.
*/
`default_nettype none
`include "ccmivb_regs.svh"
interface ccmivb_if;
  logic req;
  logic rx;
  logic ext_fmt;
  logic [`CCMIVB_SN_W-1:0] seq;
  logic [`CCMIVB_LEN_W-1:0] sdu_len;
  logic setup;
  logic [`CCMIVB_LCN_W-1:0] link_connection_number;
  logic key_ok;
  logic setup_fail;
  logic iv_valid;
  logic [127:0] iv;
  modport builder (input req, rx, ext_fmt, seq, sdu_len, setup, link_connection_number, key_ok,
    output setup_fail, iv_valid, iv);
  modport framer (output req, rx, ext_fmt, seq, sdu_len, setup, link_connection_number, key_ok,
    input setup_fail, iv_valid, iv);
endinterface : ccmivb_if
`default_nettype wire

// ### logic/ccmivb_framer.sv
/*
  Framer end: passes one IV request per SDU and link setup straight through to the
  builder, keeping no packet number of its own, and exposes the registered IV.
  Assumes the user side presents one-cycle strobes on sys_clk_in.
*/
`default_nettype none
`include "ccmivb_regs.svh"
module ccmivb_framer (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic user_setup_in,
  input wire logic [`CCMIVB_LCN_W-1:0] user_lcn_in,
  input wire logic user_key_ok_in,
  input wire logic user_req_in,
  input wire logic user_rx_in,
  input wire logic user_ext_fmt_in,
  input wire logic [`CCMIVB_SN_W-1:0] user_seq_in,
  input wire logic [`CCMIVB_LEN_W-1:0] user_sdu_len_in,
  output logic user_busy_out,
  output logic user_iv_valid_out,
  output logic [127:0] user_iv_out,
  output logic user_setup_fail_out,
  ccmivb_if.framer link
);
  logic [127:0] iv_reg;
  logic valid_reg;
  logic fail_reg;

  // Straight pass of the request group; the builder takes it in the same cycle
  assign link.req = user_req_in;
  assign link.rx = user_rx_in;
  assign link.ext_fmt = user_ext_fmt_in;
  assign link.seq = user_seq_in;
  assign link.sdu_len = user_sdu_len_in;
  assign link.setup = user_setup_in;
  assign link.link_connection_number = user_lcn_in;
  assign link.key_ok = user_key_ok_in; // R19
  assign user_busy_out = 1'b0;

  // Answers registered so data outputs come from flip-flops
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iv_reg <= 128'h0;
      valid_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      valid_reg <= link.iv_valid;
      fail_reg <= link.setup_fail; // R19
      if (link.iv_valid) begin
        iv_reg <= link.iv;
      end
    end
  end
  assign user_iv_valid_out = valid_reg;
  assign user_iv_out = iv_reg;
  assign user_setup_fail_out = fail_reg;
endmodule : ccmivb_framer
`default_nettype wire

// ### logic/ccmivb_builder.sv
/*
  IV builder and packet-number tracker for connection-oriented links.
  Assumes the framer strobes req one cycle per SDU and setup once per link on sys_clk_in.
*/
// Summary of operation
// R1 - Form 16-octet IV, octets 1-13 nonce
// R2 - Octet 0 is flag byte 09
// R3 - Octet 1 always zero
// R4 - Octets 2-7 packet number, big endian
// R5 - Fixed identity 12 low bits, first
// R6 - Octet 8/9 high nibble hold fixed identity
// R7 - Portable identity fills octets 9-11
// R8 - Octet 12 bits 2-0 connection number
// R9 - Octet 12 bits 6-3 are zero
// R10 - Octet 12 bit 7 gives direction
// R11 - Separate IV per direction
// R12 - Keep connection number from link creation
// R13 - Octet 13 is zero
// R14 - Octets 14-15 SDU length, big endian
// R15 - Packet number low bits equal sequence
// R16 - Upper bits kept locally, bump on wrap
// R17 - Receiver rebuilds upper from previous number
// R18 - No plaintext from link setup onward
// R19 - Missing key fails call setup
// R20 - Fresh key when sequence resets
// R21 - Key not shared with other ciphering
// R22 - Integrity code appended after message
// R23 - Engine uses 128-bit AES key
// R24 - Smaller received sequence means wrap; code also wraps on an equal one
`default_nettype none
`include "ccmivb_regs.svh"
module ccmivb_builder #(
  parameter logic [`CCMIVB_FPI_W-1:0] FIXED_ID = 12'h000,
  parameter logic [`CCMIVB_PPI_W-1:0] PORT_ID = 20'h00000,
  parameter bit IS_PORTABLE = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [`CCMIVB_FPI_W-1:0] fixed_part_access_identity_in,
  input wire logic [`CCMIVB_PPI_W-1:0] portable_part_identity_in,
  output logic link_up_out,
  output logic encrypt_en_out,
  ccmivb_if.builder link
);
  logic [`CCMIVB_LCN_W-1:0] lcn_reg;
  logic up_reg;
  logic [127:0] iv_reg;
  logic valid_reg;
  logic fail_reg;
  logic first_tx_reg;
  logic first_rx_reg;
  ccmivb_pkg::ccmivb_pn_t tx_pn_reg;
  ccmivb_pkg::ccmivb_pn_t rx_pn_reg;
  ccmivb_pkg::ccmivb_pn_t pn_next;
  logic dir_bit;

  // Next packet number: low bits from the sequence, upper bits bumped on wrap
  function automatic ccmivb_pkg::ccmivb_pn_t next_pn(input ccmivb_pkg::ccmivb_pn_t prev,
    input logic first, input logic ext, input logic [`CCMIVB_SN_W-1:0] sn);
    ccmivb_pkg::ccmivb_pn_t up;
    up = prev;
    if (ext) begin
      up[`CCMIVB_SN_W-1:0] = '0;
      if (!first && sn <= prev[`CCMIVB_SN_W-1:0]) begin
        up = up + `CCMIVB_PN_STEP_EXT; // R16 R24
      end
      next_pn = up | ccmivb_pkg::ccmivb_pn_t'(sn); // R15
    end else begin
      up[`CCMIVB_SN_NARROW-1:0] = '0;
      if (!first && sn[`CCMIVB_SN_NARROW-1:0] <= prev[`CCMIVB_SN_NARROW-1:0]) begin
        up = up + `CCMIVB_PN_STEP_NARROW; // R16 R17 R24
      end
      next_pn = up | ccmivb_pkg::ccmivb_pn_t'(sn[`CCMIVB_SN_NARROW-1:0]); // R15 R17
    end
  endfunction

  // Direction of this SDU; transmit from the portable side is uplink
  assign dir_bit = (IS_PORTABLE ^ link.rx) ? `CCMIVB_DIR_P2F : `CCMIVB_DIR_F2P; // R10 R11
  assign pn_next = link.rx ? next_pn(rx_pn_reg, first_rx_reg, link.ext_fmt, link.seq)
    : next_pn(tx_pn_reg, first_tx_reg, link.ext_fmt, link.seq); // R11

  // Link setup: latch connection number once, refuse without a key
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lcn_reg <= '0;
      up_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      fail_reg <= 1'b0;
      if (link.setup && !up_reg) begin
        if (link.key_ok) begin
          lcn_reg <= link.link_connection_number; // R12
          up_reg <= 1'b1;
        end else begin
          fail_reg <= 1'b1; // R19
        end
      end
    end
  end

  // Per-direction counters restart at every new link; a new key is expected then
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_pn_reg <= `CCMIVB_PN_ZERO;
      rx_pn_reg <= `CCMIVB_PN_ZERO;
      first_tx_reg <= 1'b1;
      first_rx_reg <= 1'b1;
    end else if (link.setup && !up_reg) begin
      tx_pn_reg <= `CCMIVB_PN_ZERO; // R20
      rx_pn_reg <= `CCMIVB_PN_ZERO;
      first_tx_reg <= 1'b1;
      first_rx_reg <= 1'b1;
    end else if (link.req && up_reg) begin
      if (link.rx) begin
        rx_pn_reg <= pn_next; // R17
        first_rx_reg <= 1'b0;
      end else begin
        tx_pn_reg <= pn_next; // R16
        first_tx_reg <= 1'b0;
      end
    end
  end

  // IV assembly; requests before setup are dropped so nothing goes out in clear
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iv_reg <= 128'h0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= link.req && up_reg; // R18
      if (link.req && up_reg) begin
        iv_reg <= {`CCMIVB_IV_FLAGS, // R1 R2
          `CCMIVB_IV_NRESV, // R3
          pn_next, // R4
          fixed_part_access_identity_in, // R5 R6
          portable_part_identity_in, // R7
          dir_bit, `CCMIVB_B12_RSV, lcn_reg, // R8 R9 R10
          `CCMIVB_IV_FIXED, // R13
          link.sdu_len}; // R14
      end
    end
  end

  assign link.iv = iv_reg;
  assign link.iv_valid = valid_reg;
  assign link.setup_fail = fail_reg;
  assign link_up_out = up_reg;
  assign encrypt_en_out = up_reg; // R18 R21 R22 R23
endmodule : ccmivb_builder
`default_nettype wire

// ### sim/ccmivb_monitor.sv
/* Checker for the carrier between framer and builder: IV layout and link answers.
   Assumes one clock, async active-high reset, builder on the fixed side. */
`default_nettype none
module ccmivb_monitor (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic req,
  input wire logic rx,
  input wire logic ext_fmt,
  input wire logic [8:0] seq,
  input wire logic [15:0] sdu_len,
  input wire logic setup,
  input wire logic [2:0] link_connection_number,
  input wire logic key_ok,
  input wire logic setup_fail,
  input wire logic iv_valid,
  input wire logic [127:0] iv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up_reg;
  logic [2:0] lcn_reg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Link state rebuilt from the wire; only one link exists until reset
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) up_reg <= 1'h0;
    else if (setup && key_ok) up_reg <= 1'h1;
  end
  // Number frozen at creation, later setups must not move it
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) lcn_reg <= 3'h0;
    else if (setup && key_ok && !up_reg) lcn_reg <= link_connection_number;
  end
  property p_head; iv_valid |-> iv[127:112] == 16'h0900; endproperty
  a_head: assert property (p_head) else $error("iv head octets wrong");
  property p_zero; iv_valid |-> iv[30:27] == 4'h0 && iv[23:16] == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("iv zero fields wrong");
  property p_dir; iv_valid |-> iv[31] == $past(rx); endproperty
  a_dir: assert property (p_dir) else $error("iv direction bit wrong");
  property p_len; iv_valid |-> iv[15:0] == $past(sdu_len); endproperty
  a_len: assert property (p_len) else $error("iv length wrong");
  property p_low; iv_valid |-> iv[71:64] == 8'($past(seq)); endproperty
  a_low: assert property (p_low) else $error("iv low sequence bits wrong");
  property p_ext; iv_valid && $past(ext_fmt) |-> iv[72:64] == $past(seq); endproperty
  a_ext: assert property (p_ext) else $error("iv nine bit sequence wrong");
  property p_lcn; iv_valid |-> iv[26:24] == lcn_reg; endproperty
  a_lcn: assert property (p_lcn) else $error("iv link number wrong");
  property p_ans; req && up_reg |=> iv_valid; endproperty
  a_ans: assert property (p_ans) else $error("request not answered");
  property p_only; iv_valid |-> $past(req) && $past(up_reg); endproperty
  a_only: assert property (p_only) else $error("iv without link or request");
  property p_fail; setup && !key_ok && !up_reg |=> setup_fail; endproperty
  a_fail: assert property (p_fail) else $error("keyless setup not failed");
  c_up: cover property (iv_valid && iv[31]);
  c_fail: cover property (setup_fail);
  c_ext: cover property (iv_valid && $past(ext_fmt));
endmodule // ccmivb_monitor
`default_nettype wire

// ### sim/ccm_iv_builder_seq_tracker_test.sv
/* Bench: framer and builder joined by the carrier, checker beside it.
   Assumes the design files are compiled first. */
`default_nettype none
module ccm_iv_builder_seq_tracker_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, st = 0, ky = 0, rq = 0, rx = 0, ex = 0;
  logic [2:0] lc = 0;
  logic [8:0] sq = 0;
  logic [15:0] ln = 0;
  logic fv, ff, up, en;
  logic [127:0] fiv;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  ccmivb_if link();
  ccmivb_framer ccmivb_framer_inst(.sys_clk_in(clk), .sys_rst_in(rst), .user_setup_in(st), .user_lcn_in(lc),
    .user_key_ok_in(ky), .user_req_in(rq), .user_rx_in(rx), .user_ext_fmt_in(ex), .user_seq_in(sq),
    .user_sdu_len_in(ln), .user_busy_out(), .user_iv_valid_out(fv), .user_iv_out(fiv),
    .user_setup_fail_out(ff), .link(link));
  ccmivb_builder ccmivb_builder_inst(.sys_clk_in(clk), .sys_rst_in(rst),
    .fixed_part_access_identity_in(12'habc), .portable_part_identity_in(20'h12345),
    .link_up_out(up), .encrypt_en_out(en), .link(link));
  ccmivb_monitor ccmivb_monitor_inst(.sys_clk_in(clk), .sys_rst_in(rst), .req(link.req), .rx(link.rx),
    .ext_fmt(link.ext_fmt), .seq(link.seq), .sdu_len(link.sdu_len), .setup(link.setup), .link_connection_number(link.link_connection_number),
    .key_ok(link.key_ok), .setup_fail(link.setup_fail), .iv_valid(link.iv_valid), .iv(link.iv));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard, far above the roughly 36 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Setup strobe; builder answers at the taking edge, framer copy one cycle later
  task automatic do_setup(input logic k, input logic [2:0] l, input logic f, input logic u);
    @(posedge clk);
    st <= 1'h1;
    ky <= k;
    lc <= l;
    @(posedge clk);
    st <= 1'h0;
    @(negedge clk);
    chk("setup_fail", f, link.setup_fail);
    chk("link_up", u, up);
    chk("encrypt_en", u, en);
    @(negedge clk);
    chk("user_setup_fail", f, ff);
  endtask
  // One SDU request; the expected IV uses link number 5 fixed at creation
  task automatic sdu(input logic r, input logic e, input logic [8:0] s, input logic [15:0] n,
    input logic [47:0] pn, input logic v);
    logic [127:0] x;
    x = {8'h09, 8'h00, pn, 12'habc, 20'h12345, r, 4'h0, 3'h5, 8'h00, n};
    @(posedge clk);
    rq <= 1'h1;
    rx <= r;
    ex <= e;
    sq <= s;
    ln <= n;
    @(posedge clk);
    rq <= 1'h0;
    @(negedge clk);
    chk("iv_valid", v, link.iv_valid);
    if (v) chk("iv", x, link.iv);
    @(negedge clk);
    chk("user_iv_valid", v, fv);
    if (v) chk("user_iv", x, fiv);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    sdu(1'h0, 1'h0, 9'h010, 16'h0004, 48'h0, 1'h0);
    do_setup(1'h0, 3'h5, 1'h1, 1'h0);
    do_setup(1'h1, 3'h5, 1'h0, 1'h1);
    sdu(1'h0, 1'h0, 9'h0fe, 16'h0001, 48'hfe, 1'h1);
    sdu(1'h0, 1'h0, 9'h0ff, 16'hffff, 48'hff, 1'h1);
    sdu(1'h0, 1'h0, 9'h002, 16'h0100, 48'h102, 1'h1);
    sdu(1'h0, 1'h0, 9'h002, 16'h0100, 48'h202, 1'h1);
    do_setup(1'h1, 3'h2, 1'h0, 1'h1);
    sdu(1'h1, 1'h1, 9'h1ff, 16'h0020, 48'h1ff, 1'h1);
    sdu(1'h1, 1'h1, 9'h005, 16'h0020, 48'h205, 1'h1);
    sdu(1'h0, 1'h0, 9'h003, 16'h0002, 48'h203, 1'h1);
    print_verdict();
  end
endmodule // ccm_iv_builder_seq_tracker_test
`default_nettype wire
